/* File: design/gcml_pkg.sv */
// constants, field indices and timing figures shared by the gpio and clock mask loader
// assumes a 125 MHz system clock and an external parallel-load shift register for the mask
//
// How it works
// - enable-set ones make pins driven outputs
// - enable-clear ones tristate pins, input only
// - zero bits in set/clear fields change nothing
// - after reset every pin is input only
// - input field reads live pin levels, read-only
// - output-set ones drive pin high when enabled
// - output-clear ones drive pin low when enabled
// - stored output values reset to zero
// - five byte-wide fields, low four bits used
// - loading starts once primary reset releases
// - secondary reset held for 23 shift periods
// - pin 0 shift clock, 33 MHz max
// - pin 2 low one shift period, then high
// - sixteen mask bits arrive MSB first
// - bit pairs 7..0 gate clocks 3..0
// - bits 8..12 gate clocks 4..8 singly
// - bit 13 gates clock 9; 14,15 reserved
// - after shift tristate pins, release reset conditionally
// - mask stays writable by configuration writes
// - mask input tied low/high enables/disables all
// - pin 3 input masks command enables in live mode
package gcml_pkg;
  // system clock and shift clock limits
  localparam int CLK_MHZ = 125; // system clock rate
  localparam int SHIFT_MAX_MHZ = 33; // highest shift clock rate
  localparam int SHIFT_HALF_CYC = (CLK_MHZ + 2 * SHIFT_MAX_MHZ - 1) / (2 * SHIFT_MAX_MHZ); // rounds up
  localparam int SHIFT_PERIOD_CYC = 2 * SHIFT_HALF_CYC;
  localparam int SAMPLE_PHASE = SHIFT_HALF_CYC + 1; // one cycle after the synced previous edge
  localparam int LOAD_PERIODS = 23; // total shift clock periods of a mask load
  localparam int MASK_BITS = 16;
  localparam int FIRST_SAMPLE_PERIOD = 1; // period 0 is the load period
  // pin roles while loading
  localparam int PIN_SHCLK = 0;
  localparam int PIN_SHCTL = 2;
  localparam int PIN_LIVE = 3;
  localparam int NUM_PINS = 4;
  localparam int NUM_SEC_CLKS = 10;
  localparam int NUM_PAIR_CLKS = 4; // clocks gated by a pair of bits
  localparam int SINGLE_BIT_BASE = 8; // first single-bit mask position
  localparam int OWN_CLK_BIT = 13; // gates the feedback clock
  // configuration field indices
  localparam logic [2:0] FLD_OUT_SET = 3'h0;
  localparam logic [2:0] FLD_OUT_CLR = 3'h1;
  localparam logic [2:0] FLD_OE_SET = 3'h2;
  localparam logic [2:0] FLD_OE_CLR = 3'h3;
  localparam logic [2:0] FLD_INPUT = 3'h4;
  localparam logic [2:0] FLD_CLK_MASK = 3'h5;
  // reset values
  localparam logic [3:0] RST_PIN_OUT = 4'h0;
  localparam logic [3:0] RST_PIN_OE = 4'h0;
  localparam logic [15:0] RST_CLK_MASK = 16'h0000;
  // loader states, gray along the path
  typedef enum logic [1:0] {
    GCML_ST_START = 2'b00,
    GCML_ST_LOAD = 2'b01,
    GCML_ST_SHIFT = 2'b11,
    GCML_ST_DONE = 2'b10
  } gcml_state_e;
endpackage : gcml_pkg

/* File: design/gcml_top.sv */
// general purpose pin port of the bridge and the secondary clock mask loader
// assumes clk_sys at 125 MHz, pins and mask input asynchronous to it, config port synchronous
`timescale 1ns/1ps
module gcml_top
  import gcml_pkg::*;
#(
  parameter int BUF_DEPTH = 2, // read answer buffer entries
  parameter int BUF_WIDTH = 16 // read answer width
) (
  input wire logic clk_sys,
  input wire logic rst, // primary reset, async active high
  // configuration access
  input wire logic cfgWrEn, // one-cycle write strobe
  input wire logic cfgRdReq, // read request, taken when cfgRdReqReady
  output logic cfgRdReqReady,
  input wire logic [2:0] cfgAddr, // field index
  input wire logic [15:0] cfgWrData,
  output logic cfgRdValid,
  input wire logic cfgRdReady,
  output logic [BUF_WIDTH-1:0] cfgRdData,
  // general purpose pins, three signals each
  input wire logic [3:0] gpioIn,
  output logic [3:0] gpioOut,
  output logic [3:0] gpioOe,
  input wire logic clock_mask_serial_in,
  // secondary reset and clocks
  input wire logic secResetBit, // bridge control secondary reset bit
  output logic secResetN, // secondary reset, low active
  output logic [9:0] secondary_clock_outputs,
  // live insertion
  input wire logic liveInsertMode,
  input wire logic [2:0] cmdEnables, // io, memory, master enables as written
  output logic [2:0] effEnables // enables as seen by the bridge
);
  initial begin
    if (BUF_DEPTH != 2 || BUF_WIDTH < MASK_BITS) $error("gcml_top: buffer must be 2 deep, 16 wide or more");
  end

  // three-flop synchronisers for pins and mask input
  logic [4:0] syncA_ff;
  logic [4:0] syncB_ff;
  logic [4:0] syncC_ff;
  logic [4:0] inFilt_ff; // accepted level, changes when B and C agree
  wire [4:0] rawIn = {clock_mask_serial_in, gpioIn};
  wire [4:0] nxt_inFilt;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_filt
      assign nxt_inFilt[gi] = (syncB_ff[gi] == syncC_ff[gi]) ? syncC_ff[gi] : inFilt_ff[gi];
    end
  endgenerate
  wire [3:0] pinLevel = inFilt_ff[3:0];
  wire maskBit = inFilt_ff[4];

  // synchroniser chain; only the second flop reads the first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncA_ff <= 5'h00;
      syncB_ff <= 5'h00;
      syncC_ff <= 5'h00;
      inFilt_ff <= 5'h00;
    end else begin
      syncA_ff <= rawIn;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
      inFilt_ff <= nxt_inFilt;
    end
  end

  // loader sequencing
  gcml_state_e state_ff;
  gcml_state_e nxt_state;
  logic [$clog2(SHIFT_PERIOD_CYC)-1:0] phase_ff;
  logic [4:0] period_ff;
  localparam logic [$clog2(SHIFT_PERIOD_CYC)-1:0] PH_LAST = ($clog2(SHIFT_PERIOD_CYC))'(SHIFT_PERIOD_CYC - 1);
  localparam logic [$clog2(SHIFT_PERIOD_CYC)-1:0] PH_HALF = ($clog2(SHIFT_PERIOD_CYC))'(SHIFT_HALF_CYC);
  localparam logic [$clog2(SHIFT_PERIOD_CYC)-1:0] PH_SAMP = ($clog2(SHIFT_PERIOD_CYC))'(SAMPLE_PHASE);
  localparam logic [4:0] PER_LAST = 5'(LOAD_PERIODS - 1);
  localparam logic [4:0] PER_FIRST = 5'(FIRST_SAMPLE_PERIOD);
  localparam logic [4:0] PER_LASTBIT = 5'(FIRST_SAMPLE_PERIOD + MASK_BITS - 1);
  wire loading = (state_ff == GCML_ST_LOAD) || (state_ff == GCML_ST_SHIFT);
  wire periodEnd = (phase_ff == PH_LAST);
  wire shiftClkHigh = (phase_ff >= PH_HALF); // rising edge mid period, control steady around it
  wire sampleNow = (state_ff == GCML_ST_SHIFT) && (phase_ff == PH_SAMP) &&
                   (period_ff >= PER_FIRST) && (period_ff <= PER_LASTBIT);

  // next state: start loads straight away, since secondary reset is held by us
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      GCML_ST_START: nxt_state = GCML_ST_LOAD;
      GCML_ST_LOAD: if (periodEnd) nxt_state = GCML_ST_SHIFT; // one load period
      GCML_ST_SHIFT: if (periodEnd && period_ff == PER_LAST) nxt_state = GCML_ST_DONE;
      GCML_ST_DONE: nxt_state = GCML_ST_DONE; // mask input ignored from now
      default: nxt_state = GCML_ST_START;
    endcase
  end

  // state, phase divider and period counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= GCML_ST_START;
      phase_ff <= '0;
      period_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= (loading && !periodEnd) ? phase_ff + 1'b1 : '0;
      if (loading && periodEnd) begin
        period_ff <= period_ff + 5'h01;
      end
    end
  end

  // registers: pin output data, pin enables, clock disable mask
  logic [3:0] pinOut_ff;
  logic [3:0] pinOe_ff;
  logic [15:0] clkMask_ff;
  wire wrOutSet = cfgWrEn && (cfgAddr == FLD_OUT_SET);
  wire wrOutClr = cfgWrEn && (cfgAddr == FLD_OUT_CLR);
  wire wrOeSet = cfgWrEn && (cfgAddr == FLD_OE_SET);
  wire wrOeClr = cfgWrEn && (cfgAddr == FLD_OE_CLR);
  wire wrMask = cfgWrEn && (cfgAddr == FLD_CLK_MASK);
  wire [3:0] setBits = cfgWrData[3:0];
  // zero bits keep the old value; a set and clear in one write cannot meet, one field per write
  wire [3:0] nxt_pinOut = wrOutSet ? (pinOut_ff | setBits) :
                          wrOutClr ? (pinOut_ff & ~setBits) : pinOut_ff;
  wire [3:0] nxt_pinOe = wrOeSet ? (pinOe_ff | setBits) :
                         wrOeClr ? (pinOe_ff & ~setBits) : pinOe_ff;
  // a config write wins over a shifted bit; the serial bit never arrives after loading
  wire [15:0] nxt_clkMask = wrMask ? cfgWrData :
                            sampleNow ? {clkMask_ff[14:0], maskBit} : clkMask_ff;

  // register file update
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinOut_ff <= RST_PIN_OUT;
      pinOe_ff <= RST_PIN_OE;
      clkMask_ff <= RST_CLK_MASK;
    end else begin
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= nxt_pinOe;
      clkMask_ff <= nxt_clkMask;
    end
  end

  // pin drive: loader owns pins 0 and 2 while loading, registers once done, all pins off in start
  logic [3:0] gpioOut_ff;
  logic [3:0] gpioOe_ff;
  wire [3:0] ldOe = 4'((1 << PIN_SHCLK) | (1 << PIN_SHCTL)); // pins 1 and 3 idle
  wire ldCtl = (state_ff == GCML_ST_SHIFT); // low in load period, high to shift
  wire [3:0] ldOut = 4'({3'h0, shiftClkHigh} << PIN_SHCLK) | 4'({3'h0, ldCtl} << PIN_SHCTL);
  wire [3:0] nxt_gpioOe = loading ? ldOe : (state_ff == GCML_ST_DONE) ? pinOe_ff : 4'h0;
  wire [3:0] nxt_gpioOut = loading ? ldOut : (state_ff == GCML_ST_DONE) ? (pinOut_ff & pinOe_ff) : 4'h0;
  assign gpioOe = gpioOe_ff;
  assign gpioOut = gpioOut_ff;

  // registered pin drive
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gpioOe_ff <= 4'h0;
      gpioOut_ff <= 4'h0;
    end else begin
      gpioOe_ff <= nxt_gpioOe;
      gpioOut_ff <= nxt_gpioOut;
    end
  end

  // secondary reset: held through loading, then follows the control bit
  logic secResetN_ff;
  wire nxt_secResetN = (state_ff == GCML_ST_DONE) && !secResetBit;
  assign secResetN = secResetN_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      secResetN_ff <= 1'b0;
    end else begin
      secResetN_ff <= nxt_secResetN;
    end
  end

  // secondary clock disables decoded from the mask
  wire [9:0] clkOff;
  generate
    for (gi = 0; gi < NUM_PAIR_CLKS; gi++) begin : g_pair
      assign clkOff[gi] = &clkMask_ff[2*gi+1 -: 2]; // any zero keeps it running
    end
    for (gi = NUM_PAIR_CLKS; gi < NUM_SEC_CLKS - 1; gi++) begin : g_single
      assign clkOff[gi] = clkMask_ff[SINGLE_BIT_BASE + gi - NUM_PAIR_CLKS];
    end
  endgenerate
  assign clkOff[NUM_SEC_CLKS-1] = clkMask_ff[OWN_CLK_BIT]; // bits 14, 15 unused

  // secondary clocks: divided toggle; enable only changes while the output is high
  logic secPhase_ff;
  logic [9:0] clkOffHeld_ff;
  logic [9:0] secClk_ff;
  wire [9:0] nxt_clkOffHeld = secPhase_ff ? clkOffHeld_ff : clkOff; // sampled at the edge that starts the high half
  wire [9:0] nxt_secClk = {10{!secPhase_ff}} | nxt_clkOffHeld; // stopped clock sits high
  assign secondary_clock_outputs = secClk_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      secPhase_ff <= 1'b0;
      clkOffHeld_ff <= 10'h000;
      secClk_ff <= 10'h3FF;
    end else begin
      secPhase_ff <= !secPhase_ff;
      clkOffHeld_ff <= nxt_clkOffHeld;
      secClk_ff <= nxt_secClk;
    end
  end

  // live insertion: pin 3 as input, high, stops io/mem/master enables
  wire liveHalt = liveInsertMode && !pinOe_ff[PIN_LIVE] && pinLevel[PIN_LIVE];
  logic [2:0] effEnables_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      effEnables_ff <= 3'h0;
    end else begin
      effEnables_ff <= liveHalt ? 3'h0 : cmdEnables;
    end
  end
  assign effEnables = effEnables_ff;

  // read decode; set fields read back the state they change
  wire [15:0] rdMux = (cfgAddr == FLD_OUT_SET || cfgAddr == FLD_OUT_CLR) ? {12'h000, pinOut_ff} :
                      (cfgAddr == FLD_OE_SET || cfgAddr == FLD_OE_CLR) ? {12'h000, pinOe_ff} :
                      (cfgAddr == FLD_INPUT) ? {12'h000, pinLevel} :
                      (cfgAddr == FLD_CLK_MASK) ? clkMask_ff : 16'h0000;

  // two-entry read answer buffer; a stalled reader holds off new reads
  logic [BUF_WIDTH-1:0] buf_ff [BUF_DEPTH];
  logic wrPtr_ff;
  logic rdPtr_ff;
  logic [1:0] count_ff;
  wire bufFull = (count_ff == 2'(BUF_DEPTH));
  wire bufEmpty = (count_ff == 2'h0);
  wire push = cfgRdReq && !bufFull;
  wire pop = cfgRdReady && !bufEmpty;
  assign cfgRdReqReady = !bufFull;
  assign cfgRdValid = !bufEmpty;
  assign cfgRdData = buf_ff[rdPtr_ff];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      count_ff <= 2'h0;
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
    end else begin
      if (push) begin
        buf_ff[wrPtr_ff] <= BUF_WIDTH'(rdMux);
        wrPtr_ff <= !wrPtr_ff;
      end
      if (pop) begin
        rdPtr_ff <= !rdPtr_ff;
      end
      count_ff <= count_ff + 2'(push) - 2'(pop);
    end
  end

  // checks on the pin port and the loader
  oe_set_effect_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrOeSet |=> ((pinOe_ff & $past(setBits)) == $past(setBits)))
    else $error("enable set write did not enable pin");
  oe_clear_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrOeClr |=> ((pinOe_ff & $past(setBits)) == 4'h0) && ((pinOe_ff | $past(setBits)) == ($past(pinOe_ff) | $past(setBits))))
    else $error("enable clear write wrong");
  pins_idle_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == GCML_ST_SHIFT) |=> (gpioOe == ldOe))
    else $error("loader pins not driven as required");
  ctl_low_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(state_ff == GCML_ST_LOAD) |=> (!gpioOut[PIN_SHCTL]) [*4] ##1 gpioOut[PIN_SHCTL])
    else $error("shift control not low for one period then high");
  reset_held_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    loading |=> !secResetN)
    else $error("secondary reset released during load");
  load_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(state_ff == GCML_ST_LOAD) |-> ##(92) (state_ff == GCML_ST_DONE) && $past(state_ff) == GCML_ST_SHIFT)
    else $error("mask load length wrong");
  release_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == GCML_ST_DONE && !secResetBit) |=> secResetN)
    else $error("secondary reset not released after load");
  mask_shift_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sampleNow && !wrMask) |=> clkMask_ff == {$past(clkMask_ff[14:0]), $past(maskBit)})
    else $error("mask bit not shifted in at lsb");
  stopped_clk_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkOff[0] [*3] |-> secClk_ff[0])
    else $error("disabled clock not high");
  live_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
    liveHalt |=> effEnables == 3'h0)
    else $error("live insertion did not mask enables");
endmodule : gcml_top

/* File: sim/gcml_shreg.sv */
// partner model: parallel-load shift register holding the clock mask straps
// assumes pin 0 is its shift clock and pin 2 its load/shift control
`timescale 1ns/1ps
module gcml_shreg (
  input wire logic shClk,
  input wire logic shCtl,
  input wire logic [15:0] straps,
  output logic serOut
);
  logic [15:0] shReg = 16'h0000; // strap image being shifted out
  // load is level sensitive while control is low, so a clock edge then reloads
  always @(posedge shClk or negedge shCtl) begin
    if (!shCtl) begin
      shReg <= straps;
    end else begin
      shReg <= {shReg[14:0], ~shReg[15]}; // msb first, tail toggles
    end
  end
  assign serOut = shReg[15];
endmodule : gcml_shreg

/* File: sim/gcml_top_test.sv */
// self-checking bench of the pin port and clock mask loader
// assumes the shift register partner in gcml_shreg; drives 1 ns after each rising edge
`timescale 1ns/1ps
module gcml_top_test;
  import gcml_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cfgWrEn = 1'b0;
  logic cfgRdReq = 1'b0;
  logic cfgRdReady = 1'b0;
  logic secResetBit = 1'b0;
  logic liveInsertMode = 1'b0;
  logic [2:0] cfgAddr = 3'h0;
  logic [2:0] cmdEnables = 3'h0;
  logic [15:0] cfgWrData = 16'h0000;
  logic [15:0] straps = 16'h0000; // partner strap image
  logic [3:0] extPins = 4'h0; // far side level when a pin is not driven
  logic cfgRdReqReady, cfgRdValid, secResetN, serIn, prev;
  logic [15:0] cfgRdData, rdv, mask;
  logic [3:0] gpioOut, gpioOe, pins, outM, oeM; // outM/oeM: expected state
  logic [9:0] secondary_clock_outputs;
  logic [2:0] effEnables;
  int fails = 0;
  int checked = 0;
  int rises, a;
  always #4 clk_sys = ~clk_sys;
  // wire level: the port wins where it drives
  assign pins = (gpioOe & gpioOut) | (~gpioOe & extPins);
  gcml_shreg u_shreg (.shClk(pins[0]), .shCtl(pins[2]), .straps(straps), .serOut(serIn));
  gcml_top u_dut (.clk_sys(clk_sys), .rst(rst), .cfgWrEn(cfgWrEn), .cfgRdReq(cfgRdReq),
    .cfgRdReqReady(cfgRdReqReady), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdValid(cfgRdValid),
    .cfgRdReady(cfgRdReady), .cfgRdData(cfgRdData), .gpioIn(pins), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .clock_mask_serial_in(serIn), .secResetBit(secResetBit), .secResetN(secResetN),
    .secondary_clock_outputs(secondary_clock_outputs), .liveInsertMode(liveInsertMode),
    .cmdEnables(cmdEnables), .effEnables(effEnables));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done;
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // one write strobe, then an idle edge so strobes never merge
  task automatic wr(input logic [2:0] ad, input logic [15:0] d);
    cfgWrEn = 1'b1;
    cfgAddr = ad;
    cfgWrData = d;
    tick(1);
    cfgWrEn = 1'b0;
    tick(1);
  endtask : wr
  // read with an empty answer buffer, so the request is taken at once
  task automatic rd(input logic [2:0] ad, output logic [15:0] d);
    cfgRdReq = 1'b1;
    cfgAddr = ad;
    tick(1);
    cfgRdReq = 1'b0;
    for (int i = 0; i < 8 && cfgRdValid !== 1'b1; i++) tick(1);
    d = cfgRdData;
    cfgRdReady = 1'b1;
    tick(1);
    cfgRdReady = 1'b0;
  endtask : rd
  // clock enables implied by a mask: pairs, singles, then the feedback clock
  function automatic logic [9:0] expEn(input logic [15:0] m);
    logic [9:0] e;
    for (int i = 0; i < 4; i++) e[i] = ~(m[2*i] & m[2*i+1]);
    for (int i = 4; i < 9; i++) e[i] = ~m[i+4];
    e[9] = ~m[13];
    return e;
  endfunction : expEn
  // an enabled clock shows a low within four cycles, a disabled one never does
  task automatic clks(input logic [15:0] m);
    logic [9:0] lows;
    lows = 10'h000;
    repeat (4) begin
      tick(1);
      lows |= ~secondary_clock_outputs;
    end
    chk("clocks", expEn(m), lows);
  endtask : clks
  // primary reset, then watch the whole mask load
  task automatic load(input logic [15:0] s, input logic b);
    straps = s;
    secResetBit = b;
    extPins = 4'h0;
    rst = 1'b1;
    tick(8);
    chk("oe in reset", 0, gpioOe);
    chk("out in reset", 0, gpioOut);
    rst = 1'b0;
    rises = 0;
    prev = 1'b0;
    for (int i = 0; i < 120; i++) begin
      tick(1);
      if (gpioOe[0] && gpioOut[0] && !prev) rises++;
      prev = gpioOut[0];
      if (i == 3) chk("load ctl", 16'h0050, {8'h00, gpioOe, 3'h0, gpioOut[2]});
      if (i == 12) chk("shift ctl", 1, gpioOut[2]);
      if (i == 80) chk("sec held", 0, secResetN);
    end
    chk("clock rises", 23, rises);
    chk("pins released", 0, gpioOe);
    chk("sec release", !b, secResetN);
    rd(3'h5, rdv);
    chk("mask", s, rdv);
    clks(s);
  endtask : load
  initial begin
    void'($urandom(27062));
    load($urandom() & 16'hDFFF, 1'b0);
    rd(3'h0, rdv);
    chk("out reset", 0, rdv);
    rd(3'h2, rdv);
    chk("oe reset", 0, rdv);
    load(16'hFFFF, 1'b1);
    secResetBit = 1'b0;
    tick(4);
    chk("sec clear", 1, secResetN);
    load(16'h0000, 1'b0);
    oeM = 4'h0;
    outM = 4'h0;
    repeat (24) begin
      a = $urandom() % 8;
      if (a == 5) a = 7;
      mask = $urandom();
      extPins = $urandom();
      wr(a[2:0], mask);
      case (a)
        0: outM |= mask[3:0];
        1: outM &= ~mask[3:0];
        2: oeM |= mask[3:0];
        3: oeM &= ~mask[3:0];
        default: ; // input and unmapped writes change nothing
      endcase
      tick(6);
      chk("oe", oeM, gpioOe);
      chk("out", outM & oeM, gpioOut & gpioOe);
      rd(3'h4, rdv);
      chk("levels", pins, rdv);
    end
    rd(3'h7, rdv);
    chk("unmapped", 0, rdv);
    mask = $urandom();
    wr(3'h5, mask);
    rd(3'h5, rdv);
    chk("mask write", mask, rdv);
    tick(2);
    clks(mask);
    // fill the answer buffer with the reader stalled, third request refused
    cfgRdReq = 1'b1;
    cfgAddr = 3'h5;
    tick(1);
    cfgAddr = 3'h0;
    tick(1);
    chk("buf full", 0, cfgRdReqReady);
    tick(1);
    cfgRdReq = 1'b0;
    chk("head", mask, cfgRdData);
    cfgRdReady = 1'b1;
    tick(1);
    chk("second", outM, cfgRdData);
    tick(1);
    cfgRdReady = 1'b0;
    chk("drained", 0, cfgRdValid);
    wr(3'h3, 16'h0008);
    liveInsertMode = 1'b1;
    cmdEnables = $urandom();
    extPins = 4'h8;
    tick(8);
    chk("live mask", 0, effEnables);
    extPins = 4'h0;
    tick(8);
    chk("live off", cmdEnables, effEnables);
    test_done();
  end
  // cut a hang short well after the expected run of about 700 cycles
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule : gcml_top_test
